/* core/tcsp_device.sv */
// Converter end of the serial port: command capture, busy, result shift-out.
// Assumes link pins are asynchronous to MCLK and sampled by two flip-flops.
`timescale 1ns/10ps

module tcsp_device
   import tcsp_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   input  wire logic        MCLK,          // System clock
   input  wire logic        RST_B,         // Async reset, active low
   tcsp_if.device           LINK,          // Serial link
   input  wire logic [11:0] SAMPLE,        // Analog result to report
   output logic      [6:0]  CMD_OPTIONS,   // Last command option bits
   output logic             POWERED,       // Converter powered up
   output logic             REF_ON         // Internal reference enabled
);
   // Link synchronisers and edges
   logic [1:0]      sclk_s_q;
   logic [1:0]      cs_s_q;
   logic [1:0]      din_s_q;
   logic            sclk_d1_q;
   logic            rise;
   logic            fall;
   logic            cs_n;
   logic            conv_end;
   logic            cmd_end;
   // Frame state
   tcsp_dev_t       state_q;
   logic [2:0]      bit_cnt_q;
   logic [4:0]      out_cnt_q;
   logic [7:0]      cmd_q;
   logic [3:0]      conv_cnt_q;
   logic [15:0]     shift_q;
   logic            have_result_q;
   logic            dout_q;
   logic            busy_n_q;
   logic [1:0]      pwr_mode_q;

   // Last cycle of a conversion
   function automatic logic conv_last(input tcsp_dev_t st, input logic [3:0] cnt);
      conv_last = (st == DEV_CONV) && (cnt == 4'(CONV_LEN - 1));
   endfunction : conv_last

   // Eighth command bit arrives on this rise
   function automatic logic cmd_last(input tcsp_dev_t st, input logic rs,
                                     input logic [2:0] cnt);
      cmd_last = (st == DEV_CMD) && rs && (cnt == 3'(CMD_BITS - 1));
   endfunction : cmd_last

   // Two-flop synchronisers; chip select resets high so no frame starts in reset
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_s_q  <= 2'h0;
         cs_s_q    <= 2'h3;
         din_s_q   <= 2'h0;
         sclk_d1_q <= 1'b0;
      end else begin
         sclk_s_q  <= {sclk_s_q[0], LINK.serial_clock};
         cs_s_q    <= {cs_s_q[0], LINK.chip_select_n};
         din_s_q   <= {din_s_q[0], LINK.serial_in};
         sclk_d1_q <= sclk_s_q[1];
      end
   end

   assign rise = sclk_s_q[1] & ~sclk_d1_q;
   assign fall = ~sclk_s_q[1] & sclk_d1_q;
   assign cs_n = cs_s_q[1];
   // Decoded frame events
   assign conv_end = conv_last(state_q, conv_cnt_q);
   assign cmd_end  = cmd_last(state_q, rise, bit_cnt_q);

   // Main sequence
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q   <= DEV_IDLE;
         bit_cnt_q <= 3'h0;
         cmd_q     <= 8'h00;
      end else if (cs_n) begin
         state_q <= DEV_IDLE;
      end else begin
         case (state_q)
            DEV_IDLE: begin
               if (rise && din_s_q[1]) begin
                  state_q   <= DEV_CMD;
                  cmd_q     <= 8'h01;
                  bit_cnt_q <= 3'h1;
               end
            end

            DEV_CMD: begin
               if (rise) begin
                  cmd_q     <= {cmd_q[6:0], din_s_q[1]};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
               end
               if (cmd_end) begin
                  state_q <= DEV_CONV;
               end
            end

            DEV_CONV: begin
               if (conv_end) begin
                  state_q <= DEV_OUT;
               end
            end

            DEV_OUT: begin
               // The fall after the sixteenth read rise ends the frame
               if (fall && out_cnt_q == 5'(FRAME_BITS)) begin
                  state_q <= DEV_IDLE;
               end
            end

            default: state_q <= DEV_IDLE;
         endcase
      end
   end

   // Conversion cycle counter
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         conv_cnt_q <= 4'h0;
      end else if (state_q == DEV_CONV && !cs_n) begin
         conv_cnt_q <= conv_cnt_q + 4'h1;
      end else begin
         conv_cnt_q <= 4'h0;
      end
   end

   // Output bit counter, one count per falling link clock
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         out_cnt_q <= 5'h0;
      end else if (state_q == DEV_OUT && !cs_n) begin
         if (fall) begin
            out_cnt_q <= out_cnt_q + 5'h1;
         end
      end else begin
         out_cnt_q <= 5'h0;
      end
   end

   // Result frame and output pin
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         have_result_q <= 1'b0;
         shift_q       <= {RESULT_RESET, 4'h0};
         dout_q        <= 1'b0;
      end else if (cs_n) begin
         dout_q <= 1'b0;
      end else if (conv_end) begin
         // Result is latched as the conversion ends
         have_result_q <= 1'b1;
         shift_q       <= {SAMPLE, 4'h0};
      end else if (state_q == DEV_OUT && fall) begin
         dout_q  <= have_result_q ? shift_q[15] : 1'b0;
         shift_q <= {shift_q[14:0], 1'b0};
      end
   end

   // Busy falls as the conversion starts and rises as it completes
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         busy_n_q <= 1'b1;
      end else begin
         busy_n_q <= ~(state_q == DEV_CONV && !cs_n);
      end
   end

   // Power state
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         pwr_mode_q <= PWR_RESET_MODE;
         POWERED    <= 1'b0;
         REF_ON     <= 1'b0;
      end else if (cs_n) begin
         POWERED <= 1'b0;
      end else if (cmd_end) begin
         // Reference follows the high power bit and survives chip select
         pwr_mode_q <= {cmd_q[PWR_LO_POS], din_s_q[1]};
         POWERED    <= 1'b1;
         REF_ON     <= cmd_q[PWR_LO_POS];
      end else if (state_q == DEV_OUT && out_cnt_q == 5'h0
                   && pwr_mode_q == PWR_AUTO_DOWN) begin
         POWERED <= 1'b0;
      end
   end

   // Data pin floats whenever chip select is seen high
   assign CMD_OPTIONS        = cmd_q[6:0];
   assign LINK.serial_out_o  = dout_q;
   assign LINK.serial_out_oe = ~cs_n;
   assign LINK.busy_n        = busy_n_q;
endmodule : tcsp_device

/* core/tcsp_host.sv */
// Host end: sends a command byte, waits for busy, reads sixteen result bits.
// Assumes busy and serial output are asynchronous and are double sampled.
`timescale 1ns/10ps
module tcsp_host
   import tcsp_pkg::*;
#(
   parameter int HALF_DIV = SCLK_HALF_DIV
) (
   input  wire logic        MCLK,       // System clock
   input  wire logic        RST_B,      // Async reset, active low
   tcsp_if.host             LINK,       // Serial link
   input  wire logic        START,      // Pulse: run one conversion
   input  wire logic [6:0]  OPTIONS,    // Command bits after start bit
   output logic             BUSY,       // Transfer in progress
   output logic             DONE,       // Pulse: result valid
   output logic      [11:0] RESULT      // Last result
);
   tcsp_hst_t   state_q;
   logic [1:0]  busy_s_q, dout_s_q;
   logic        busy_d1_q;
   logic [3:0]  div_q;
   logic        sclk_q, cs_n_q, din_q;
   logic [4:0]  cnt_q;
   logic [7:0]  tx_q;
   logic [15:0] rx_q;
   logic        tick;

   assign tick = (div_q == 4'(HALF_DIV - 1));

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         busy_s_q  <= 2'h3;
         dout_s_q  <= 2'h0;
         busy_d1_q <= 1'b1;
      end else begin
         busy_s_q  <= {busy_s_q[0], LINK.busy_n};
         dout_s_q  <= {dout_s_q[0], LINK.serial_out};
         busy_d1_q <= busy_s_q[1];
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         div_q <= 4'h0;
      end else begin
         div_q <= tick ? 4'h0 : div_q + 4'h1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= HST_IDLE;
         sclk_q  <= 1'b0;
         cs_n_q  <= 1'b1;
         din_q   <= 1'b0;
         cnt_q   <= 5'h0;
         tx_q    <= 8'h00;
         rx_q    <= 16'h0000;
         DONE    <= 1'b0;
         RESULT  <= 12'h000;
      end else begin
         DONE <= 1'b0;
         case (state_q)
            HST_IDLE: begin
               if (START) begin
                  cs_n_q  <= 1'b0;
                  tx_q    <= {1'b1, OPTIONS};
                  din_q   <= 1'b1;
                  cnt_q   <= 5'h0;
                  state_q <= HST_CMD;
               end
            end
            HST_CMD: begin
               if (tick) begin
                  sclk_q <= ~sclk_q;
                  if (sclk_q) begin
                     cnt_q <= cnt_q + 5'h1;
                     tx_q  <= {tx_q[6:0], 1'b0};
                     din_q <= tx_q[6];
                     if (cnt_q == 5'(CMD_BITS - 1)) begin
                        din_q   <= 1'b0;
                        state_q <= HST_WAIT;
                     end
                  end
               end
            end
            HST_WAIT: begin
               if (busy_d1_q && !busy_s_q[1]) begin
                  cnt_q   <= 5'h0;
                  state_q <= HST_READ;
               end
            end
            HST_READ: begin
               if (tick) begin
                  sclk_q <= ~sclk_q;
                  if (!sclk_q) begin
                     rx_q  <= {rx_q[14:0], dout_s_q[1]};
                     cnt_q <= cnt_q + 5'h1;
                  end else if (cnt_q == 5'(FRAME_BITS)) begin
                     state_q <= HST_DONE;
                  end
               end
            end
            HST_DONE: begin
               cs_n_q  <= 1'b1;
               RESULT  <= rx_q[15:4];
               DONE    <= 1'b1;
               state_q <= HST_IDLE;
            end
            default: state_q <= HST_IDLE;
         endcase
      end
   end

   assign BUSY               = (state_q != HST_IDLE);
   assign LINK.serial_clock  = sclk_q;
   assign LINK.chip_select_n = cs_n_q;
   assign LINK.serial_in     = din_q;
endmodule : tcsp_host

/* core/tcsp_if.sv */
// Interface joining the converter end and the host end of the serial link.
// Assumes the bench reads the serial output wire as resolved here from its enable.
`timescale 1ns/10ps
interface tcsp_if;
   logic serial_clock;
   logic chip_select_n;
   logic serial_in;
   logic serial_out_o;
   logic serial_out_oe;
   logic busy_n;
   logic serial_out;

   // Floating wire reads low here; the bench may model it otherwise
   assign serial_out = serial_out_oe ? serial_out_o : 1'b0;

   modport device (input serial_clock, chip_select_n, serial_in,
                   output serial_out_o, serial_out_oe, busy_n);
   modport host   (output serial_clock, chip_select_n, serial_in,
                   input serial_out, busy_n);
endinterface : tcsp_if

/* core/tcsp_pkg.sv */
// Package for the touch ADC serial port: command layout, frame counts, states.
// Assumes both ends are clocked by their own MCLK at 100 MHz.
package tcsp_pkg;
   localparam int          CMD_BITS        = 8;
   localparam int          RES_BITS        = 12;
   localparam int          FRAME_BITS      = 16;
   localparam int          CMD_START_POS   = 7;
   localparam int          PWR_HI_POS      = 1;
   localparam int          PWR_LO_POS      = 0;
   localparam logic [1:0]  PWR_AUTO_DOWN   = 2'h0;
   localparam logic [1:0]  PWR_RESET_MODE  = 2'h0;
   localparam int          MCLK_HZ         = 100_000_000;
   localparam int          SCLK_HALF_DIV   = 6;
   localparam int          CONV_CYCLES     = 4;
   localparam logic [11:0] RESULT_RESET    = 12'h000;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_CMD  = 2'b01,
      DEV_CONV = 2'b10,
      DEV_OUT  = 2'b11
   } tcsp_dev_t;

   typedef enum logic [2:0] {
      HST_IDLE = 3'b000,
      HST_CMD  = 3'b001,
      HST_WAIT = 3'b010,
      HST_READ = 3'b011,
      HST_DONE = 3'b100
   } tcsp_hst_t;
endpackage : tcsp_pkg

/* tb/tcsp_props.sv */
// Checker for the serial link between the converter end and the host end.
// Assumes the bench instantiates it beside the interface, clocked by MCLK.
`timescale 1ns/10ps
module tcsp_props (
   input wire logic MCLK,          // System clock
   input wire logic RST_B,         // Async reset, active low
   input wire logic serial_clock,  // Link clock
   input wire logic chip_select_n, // Chip select, active low
   input wire logic serial_out_o,  // Device data
   input wire logic serial_out_oe, // Device data enable
   input wire logic busy_n,        // Busy, active low
   input wire logic serial_out     // Resolved data wire
);
   logic       sclk_q;
   logic [4:0] rises_q;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   // Rising link clock edges in the current frame
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_q  <= 1'b0;
         rises_q <= 5'h00;
      end else begin
         sclk_q <= serial_clock;
         if (chip_select_n) rises_q <= 5'h00;
         else if (serial_clock && !sclk_q) rises_q <= rises_q + 5'h01;
      end
   end

   out_on_fall_a:
      assert property ($changed(serial_out_o) && serial_out_oe && $past(serial_out_oe)
         |-> !serial_clock && !$past(serial_clock)) else $error("data moved on clock high");
   float_cs_a:
      assert property (chip_select_n [*4] |-> !serial_out_oe) else $error("data not floated");
   drive_cs_a:
      assert property (!chip_select_n [*4] |-> serial_out_oe) else $error("data not driven");
   busy_len_a:
      assert property ($fell(busy_n) |-> !busy_n [*4] ##1 busy_n) else $error("busy length");
   busy_cs_a:
      assert property ($fell(busy_n) |-> !chip_select_n && serial_out_oe)
         else $error("busy fell outside frame");
   cmd_count_a:
      assert property ($fell(busy_n) |-> rises_q == 5'h08) else $error("busy not after 8 bits");
   frame_len_a:
      assert property ($rose(chip_select_n) |-> rises_q == 5'h18) else $error("frame length");
   trail_zero_a:
      assert property (rises_q > 5'h14 && serial_clock |-> serial_out == 1'b0)
         else $error("trailing bit not zero");
endmodule : tcsp_props

/* tb/touch_adc_serial_host_port_test.sv */
// Bench: host end drives converter end over the link; user sides checked.
// Assumes package, interface, both ends and checker are compiled first.
`timescale 1ns/10ps
module touch_adc_serial_host_port_test;
   import tcsp_pkg::*;
   logic        MCLK    = 1'b0;
   logic        RST_B   = 1'b0;
   logic        START   = 1'b0;
   logic [6:0]  OPTIONS = 7'h00;
   logic [11:0] SAMPLE  = 12'h000;
   logic        BUSY, DONE, POWERED, REF_ON;
   logic [11:0] RESULT;
   logic [6:0]  CMD_OPTIONS;
   logic [23:0] in_sh, out_sh;
   int          error_cnt = 0;
   int          compares  = 0;
   int          cycles    = 0;

   tcsp_if link ();
   tcsp_device tcsp_device_inst (.MCLK(MCLK), .RST_B(RST_B), .LINK(link), .SAMPLE(SAMPLE),
      .CMD_OPTIONS(CMD_OPTIONS), .POWERED(POWERED), .REF_ON(REF_ON));
   tcsp_host tcsp_host_inst (.MCLK(MCLK), .RST_B(RST_B), .LINK(link), .START(START),
      .OPTIONS(OPTIONS), .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT));
   tcsp_props tcsp_props_inst (.MCLK(MCLK), .RST_B(RST_B), .serial_clock(link.serial_clock),
      .chip_select_n(link.chip_select_n), .serial_out_o(link.serial_out_o),
      .serial_out_oe(link.serial_out_oe), .busy_n(link.busy_n), .serial_out(link.serial_out));

   always #5 MCLK = ~MCLK;

   // Wire-level capture of both data lines on rising link clock
   always @(posedge link.serial_clock) begin
      if (!link.chip_select_n) begin
         in_sh  = {in_sh[22:0], link.serial_in};
         out_sh = {out_sh[22:0], link.serial_out};
      end
   end

   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic convert(input logic [6:0] opt, input logic [11:0] smp);
      int n;
      n = 0;
      @(negedge MCLK);
      OPTIONS = opt;
      SAMPLE  = smp;
      in_sh   = 24'h000000;
      out_sh  = 24'h000000;
      START   = 1'b1;
      @(negedge MCLK);
      START = 1'b0;
      check({23'h000000, BUSY}, 24'h000001);
      while (DONE !== 1'b1 && n < 2000) begin
         @(posedge MCLK);
         #1;
         n++;
      end
      check({23'h000000, DONE}, 24'h000001);
      check({12'h000, RESULT}, {12'h000, smp});
      check({16'h0000, out_sh[15:8]}, {16'h0000, smp[11:4]});
      check({16'h0000, out_sh[7:0]}, {16'h0000, smp[3:0], 4'h0});
      check({16'h0000, in_sh[23:16]}, {16'h0000, 1'b1, opt});
      check({17'h00000, CMD_OPTIONS}, {17'h00000, opt});
      check({23'h000000, POWERED}, {23'h000000, |opt[1:0]});
      check({23'h000000, BUSY}, 24'h000000);
      check({16'h0000, out_sh[23:16]}, 24'h000000);
      repeat (4) @(posedge MCLK);
      #1;
      check({22'h000000, link.serial_out_oe, POWERED}, 24'h000000);
      check({23'h000000, REF_ON}, {23'h000000, opt[1]});
   endtask : convert

   task automatic wrap_up();
      $display("Compares %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (12) @(negedge MCLK);
      RST_B = 1'b1;
      convert(7'h7f, 12'hfff);
      convert(7'h00, 12'h000);
      convert(7'h55, 12'ha5c);
      convert(7'h2a, 12'h3a1);
      // Reset in mid-frame, then a clean conversion
      @(negedge MCLK);
      START = 1'b1;
      @(negedge MCLK);
      START = 1'b0;
      repeat (100) @(negedge MCLK);
      RST_B = 1'b0;
      repeat (3) @(negedge MCLK);
      check({11'h000, link.serial_out_oe, RESULT}, 24'h000000);
      repeat (9) @(negedge MCLK);
      RST_B = 1'b1;
      convert(7'h01, 12'h801);
      wrap_up();
   end
endmodule : touch_adc_serial_host_port_test
